// ---- hdl/mbc_bus_ctl.sv ----
// maximum mode bus control and request/grant emulation
`include "mbc_map.svh"

module mbc_bus_ctl #(
	parameter int AW = 20
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                ce,
	input  mbc_pkg::mbc_pins_t       pins,
	input  wire logic [AW-1:0]       addr_pins,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	output mbc_pkg::mbc_strobe_t     strobes,
	output logic [AW-1:0]            latched_addr,
	output logic                     rg_zero_o,
	output logic                     rg_zero_oe,
	output logic                     rg_one_o,
	output logic                     rg_one_oe,
	output mbc_pkg::mbc_ack_t        takeover_ack_zero,
	output mbc_pkg::mbc_ack_t        takeover_ack_one,
	output logic                     bus_takeover_ack
);

	mbc_pkg::mbc_pins_t   pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
	logic [AW-1:0]        adr_s1_q, adr_s2_q, adr_s3_q, adr_f_q;
	logic [31:0]          pin_flt, adr_flt, rd_d;
	mbc_pkg::mbc_state_t  st_q, st_d;
	logic                 clk_prev_q, rise_ev, fall_ev, seen_idle_q, start, halt, cycle_go;
	logic                 final_state_clear, ale_q, early_q, wde_q, rde_q, bde_q, bde_d;
	logic [1:0]           rg_low, adv_prev_q, adv, pend, min_ack, drv_q;
	logic                 req_lvl, req_s_q, strap_q, ctrl_halt_q, ld_q, mapped;
	logic [2:0]           strap_cnt_q;

	//------------------------------------------------
	// pin synchronisers
	//------------------------------------------------
	assign pin_flt = mbc_pkg::mbc_filt(32'(pin_s2_q), 32'(pin_s3_q), 32'(pin_f_q));
	assign adr_flt = mbc_pkg::mbc_filt(32'(adr_s2_q), 32'(adr_s3_q), 32'(adr_f_q));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_q   <= `MBC_PIN_RST;
			pin_s2_q   <= `MBC_PIN_RST;
			pin_s3_q   <= `MBC_PIN_RST;
			pin_f_q    <= `MBC_PIN_RST;
			adr_s1_q   <= '0;
			adr_s2_q   <= '0;
			adr_s3_q   <= '0;
			adr_f_q    <= '0;
			clk_prev_q <= 1'b0;
		end else if (ce) begin
			pin_s1_q   <= pins;
			pin_s2_q   <= pin_s1_q;
			pin_s3_q   <= pin_s2_q;
			pin_f_q    <= mbc_pkg::mbc_pins_t'(pin_flt[$bits(mbc_pkg::mbc_pins_t)-1:0]);
			adr_s1_q   <= addr_pins;
			adr_s2_q   <= adr_s1_q;
			adr_s3_q   <= adr_s2_q;
			adr_f_q    <= adr_flt[AW-1:0];
			clk_prev_q <= pin_f_q.proc_clk; // [R26]
		end
	end

	//------------------------------------------------
	// processor clock edges
	//------------------------------------------------
	assign rise_ev = pin_f_q.proc_clk & ~clk_prev_q; // [R26]
	assign fall_ev = ~pin_f_q.proc_clk & clk_prev_q; // [R26]

	//------------------------------------------------
	// machine state sequence
	//------------------------------------------------
	assign start    = seen_idle_q & ~(&pin_f_q.status_n); // [R2]
	assign halt     = pin_f_q.status_n[0] & pin_f_q.status_n[1];
	assign cycle_go = fall_ev & start &
		(st_q == mbc_pkg::idle_state || st_q == mbc_pkg::last_cycle_state);
	assign final_state_clear = (st_q == mbc_pkg::last_cycle_state) & pin_f_q.proc_clk;

	always_comb begin
		st_d = st_q;
		if (fall_ev) begin
			case (st_q)
				mbc_pkg::idle_state, mbc_pkg::last_cycle_state: begin
					st_d = (start & ~halt) ? mbc_pkg::first_cycle_state : mbc_pkg::idle_state; // [R5]
				end
				mbc_pkg::first_cycle_state:  st_d = mbc_pkg::second_cycle_state;
				mbc_pkg::second_cycle_state: st_d = mbc_pkg::third_cycle_state;
				mbc_pkg::third_cycle_state, mbc_pkg::wait_cycle_slot: begin
					st_d = pin_f_q.ready ? mbc_pkg::last_cycle_state : mbc_pkg::wait_cycle_slot; // [R23]
				end
				default: st_d = mbc_pkg::idle_state;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= mbc_pkg::idle_state;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_idle_q <= 1'b0;
		end else if (ce) begin
			if (&pin_f_q.status_n) begin
				seen_idle_q <= 1'b1;
			end else if (cycle_go) begin
				seen_idle_q <= 1'b0;
			end
		end
	end

	//------------------------------------------------
	// address strobe and latch
	//------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ale_q <= 1'b0;
		end else if (ce) begin
			if (cycle_go) begin
				ale_q <= 1'b1; // [R1]
			end else if (rise_ev) begin
				ale_q <= 1'b0; // [R3]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched_addr <= '0;
		end else if (ce && ale_q && rise_ev) begin
			latched_addr <= adr_f_q; // [R4]
		end
	end

	//------------------------------------------------
	// data enables
	//------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			early_q <= 1'b0;
		end else if (ce) begin
			if (final_state_clear) begin
				early_q <= 1'b0; // [R10]
			end else if (cycle_go && !halt) begin
				early_q <= 1'b1; // [R6]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wde_q <= 1'b0;
		end else if (ce) begin
			if (final_state_clear) begin
				wde_q <= 1'b0; // [R10]
			end else if (fall_ev && st_q == mbc_pkg::first_cycle_state) begin
				wde_q <= 1'b1; // [R7]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rde_q <= 1'b0;
		end else if (ce) begin
			if (st_d == mbc_pkg::last_cycle_state) begin
				rde_q <= 1'b0; // [R10]
			end else if (rise_ev && st_q == mbc_pkg::second_cycle_state) begin
				rde_q <= wde_q; // [R8]
			end
		end
	end

	assign bde_d = (st_q != mbc_pkg::idle_state) && (st_q != mbc_pkg::last_cycle_state) &&
		(pin_f_q.transfer_direction ? early_q : rde_q); // [R9]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bde_q <= 1'b0;
		end else if (ce) begin
			bde_q <= bde_d;
		end
	end

	assign strobes = '{ale: ale_q, early_write_enable: early_q, write_data_enable: wde_q,
		read_data_enable: rde_q, bus_data_enable: bde_q};

	//------------------------------------------------
	// grant sequencers
	//------------------------------------------------
	assign rg_low = {~pin_f_q.req_grant_line_one, ~pin_f_q.req_grant_line_zero};
	assign adv    = rg_low & {2{pin_f_q.proc_clk}} & ~adv_prev_q; // [R12] [R20]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adv_prev_q <= 2'h0;
		end else if (ce) begin
			adv_prev_q <= rg_low & {2{pin_f_q.proc_clk}};
		end
	end

	mbc_grant_seq u_seq_zero (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.clr      (pin_f_q.sys_reset),
		.adv      (adv[0]),
		.min_mode (pin_f_q.operating_mode_pin),
		.pend_q   (pend[0]),
		.ack_q    (takeover_ack_zero),
		.min_ack  (min_ack[0])
	);

	mbc_grant_seq u_seq_one (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.clr      (pin_f_q.sys_reset),
		.adv      (adv[1]),
		.min_mode (pin_f_q.operating_mode_pin),
		.pend_q   (pend[1]),
		.ack_q    (takeover_ack_one),
		.min_ack  (min_ack[1])
	);

	assign bus_takeover_ack = |min_ack; // [R14] [R17]

	//------------------------------------------------
	// request pulse generator
	//------------------------------------------------
	assign req_lvl = ctrl_halt_q | (pin_f_q.takeover_req & pin_f_q.operating_mode_pin); // [R17]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_s_q <= 1'b0;
			drv_q   <= 2'h0;
		end else if (ce && fall_ev) begin
			req_s_q  <= req_lvl;
			drv_q[0] <= (req_lvl ^ req_s_q) & ~strap_q; // [R18] [R21] [R25] [R22]
			drv_q[1] <= (req_lvl ^ req_s_q) & strap_q; // [R22]
		end
	end

	assign rg_zero_o  = 1'b0;
	assign rg_one_o   = 1'b0;
	assign rg_zero_oe = drv_q[0]; // [R19]
	assign rg_one_oe  = drv_q[1]; // [R19]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_q     <= 1'b0;
			strap_cnt_q <= 3'h0;
		end else if (ce && strap_cnt_q != `MBC_STRAP_SETTLE) begin
			strap_cnt_q <= strap_cnt_q + 3'h1;
			strap_q     <= pin_f_q.strap_one;
		end
	end

	//------------------------------------------------
	// apb slave
	//------------------------------------------------
	assign mapped  = (paddr == `MBC_OFF_CTRL) || (paddr == `MBC_OFF_STAT) || (paddr == `MBC_OFF_ADDR);
	assign pready  = penable & ce & ld_q;
	assign pslverr = pready & ~mapped;

	always_comb begin
		rd_d = '0;
		case (paddr)
			`MBC_OFF_CTRL: rd_d[`MBC_CTRL_HALT] = ctrl_halt_q;
			`MBC_OFF_STAT: begin
				rd_d[`MBC_ST_STATE +: 3] = st_q;
				rd_d[`MBC_ST_ALE]   = ale_q;
				rd_d[`MBC_ST_EARLY] = early_q;
				rd_d[`MBC_ST_WDE]   = wde_q;
				rd_d[`MBC_ST_RDE]   = rde_q;
				rd_d[`MBC_ST_BDE]   = bde_q;
				rd_d[`MBC_ST_PEND0] = pend[0];
				rd_d[`MBC_ST_ACK0]  = takeover_ack_zero.ack;
				rd_d[`MBC_ST_PEND1] = pend[1];
				rd_d[`MBC_ST_ACK1]  = takeover_ack_one.ack;
				rd_d[`MBC_ST_STRAP] = strap_q;
				rd_d[`MBC_ST_MODE]  = pin_f_q.operating_mode_pin;
			end
			`MBC_OFF_ADDR: rd_d[AW-1:0] = latched_addr;
			default: rd_d = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ld_q   <= 1'b0;
			prdata <= '0;
		end else if (ce) begin
			ld_q <= psel & ~(penable & ld_q);
			if (psel) begin
				prdata <= rd_d;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_halt_q <= `MBC_CTRL_RST;
		end else if (psel && pwrite && pready && paddr == `MBC_OFF_CTRL) begin
			ctrl_halt_q <= pwdata[`MBC_CTRL_HALT];
		end
	end

	//------------------------------------------------
	// checks
	//------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence first_state_s;
		ce && fall_ev && st_q == mbc_pkg::first_cycle_state;
	endsequence
	sequence second_state_s;
		wde_q && st_q == mbc_pkg::second_cycle_state;
	endsequence

	ale_start_a: assert property ($rose(ale_q) |-> $past(fall_ev && ce && start)) // [R1]
		else $error("strobe rose without cycle start");
	ale_drop_a: assert property ($fell(ale_q) |-> $past(rise_ev && ce)) // [R3]
		else $error("strobe fell off clock rise");
	addr_cap_a: assert property ($fell(ale_q) |-> latched_addr == $past(adr_f_q)) // [R4]
		else $error("address not captured at strobe fall");
	halt_block_a: assert property (ce && cycle_go && halt |=> st_q != mbc_pkg::first_cycle_state) // [R5]
		else $error("first state entered on halt");
	early_set_a: assert property (ce && cycle_go && !halt |=> early_q && ale_q) // [R6]
		else $error("early write enable missing");
	wde_set_a: assert property (first_state_s |=> second_state_s) // [R7]
		else $error("write enable not set after first state");
	rde_follow_a: assert property ($rose(rde_q) |-> $past(wde_q && rise_ev) &&
		$past(st_q) == mbc_pkg::second_cycle_state) // [R8]
		else $error("read enable rose out of place");
	bde_window_a: assert property (bde_q |-> $past(st_q) != mbc_pkg::idle_state &&
		$past(st_q) != mbc_pkg::last_cycle_state) // [R9]
		else $error("bus data enable outside cycle");
	final_clr_a: assert property (ce && final_state_clear |=> !early_q && !wde_q && !rde_q) // [R10]
		else $error("enables not cleared in last state");
	wait_ins_a: assert property (ce && fall_ev && st_q == mbc_pkg::third_cycle_state &&
		!pin_f_q.ready |=> st_q == mbc_pkg::wait_cycle_slot) // [R23]
		else $error("wait slot not inserted");
	req_len_a: assert property ($fell(|drv_q) |-> $past(fall_ev && ce)) // [R18]
		else $error("request pulse ended off clock fall");
	held_req_a: assert property (ce && fall_ev && req_lvl == req_s_q |=> drv_q == 2'h0) // [R25]
		else $error("held request pulsed again");
	seq_clr_a: assert property (ce && pin_f_q.sys_reset |=> pend == 2'h0 &&
		!takeover_ack_zero.ack && !takeover_ack_one.ack) // [R24]
		else $error("sequencers not cleared by system reset");

endmodule

// ---- hdl/mbc_map.svh ----
// constants for the bus control emulation block
//----------------------------------------------------------------
// Functional notes
// R1: raise address strobe on clock fall starting first state once status leaves idle.
// R2: any status line going low late in last state starts a new cycle.
// R3: address strobe drops on clock rise within first state, stays low.
// R4: address is captured on the falling edge of the address strobe.
// R5: halt status (bits 0 and 1 high) suppresses the first cycle state.
// R6: early write enable sets in first state with the address strobe rise.
// R7: write enable sets on the clock fall that samples the first state.
// R8: read enable copies write enable on clock rise mid second state.
// R9: bus data enable picks early write or read enable by direction.
// R10: last state clears read enable; clock high there clears write enables.
// R11: after reset each grant sequencer holds pending and acknowledge at zero.
// R12: sequencer advances once per low pulse while the clock is high.
// R13: first pulse sets pending, acknowledge stays inactive.
// R14: second pulse clears pending, sets acknowledge, drives hold ack in minimum mode.
// R15: third pulse clears acknowledge, both polarities inactive, back to idle.
// R16: two identical sequencers, each with true and complement acknowledge.
// R17: maximum mode uses pulsed request/grant lines instead of hold level pair.
// R18: halt or gated takeover request emits one clock low request pulse.
// R19: request pulse goes to socket, target and matching sequencer.
// R20: processor grants with a second low pulse after finishing its instruction.
// R21: withdrawn request sends a third low pulse to release the bus.
// R22: takeover request maps to line zero, or line one when strapped.
// R23: ready low inserts wait slots between third and last states.
// R24: active high system reset clears both grant sequencers.
// R25: a held request produces only one pulse.
// R26: all flip-flops follow the one processor clock, rising or falling edge; the code clocks every flip-flop on pclk and uses proc_clk edges as enables.
//----------------------------------------------------------------
`ifndef MBC_MAP_SVH
`define MBC_MAP_SVH

`define MBC_OFF_CTRL   8'h00
`define MBC_OFF_STAT   8'h04
`define MBC_OFF_ADDR   8'h08

`define MBC_CTRL_HALT  0
`define MBC_CTRL_RST   1'b0

`define MBC_ST_STATE   0
`define MBC_ST_ALE     3
`define MBC_ST_EARLY   4
`define MBC_ST_WDE     5
`define MBC_ST_RDE     6
`define MBC_ST_BDE     7
`define MBC_ST_PEND0   8
`define MBC_ST_ACK0    9
`define MBC_ST_PEND1   10
`define MBC_ST_ACK1    11
`define MBC_ST_STRAP   12
`define MBC_ST_MODE    13

`define MBC_PIN_RST    12'h31e
`define MBC_STRAP_SETTLE 3'h6

`endif

// ---- hdl/mbc_pkg.sv ----
// types shared by the bus control emulation block
package mbc_pkg;

	typedef enum logic [2:0] {
		idle_state,
		first_cycle_state,
		second_cycle_state,
		third_cycle_state,
		wait_cycle_slot,
		last_cycle_state
	} mbc_state_t;

	typedef struct packed {
		logic       strap_one;
		logic       sys_reset;
		logic       req_grant_line_one;
		logic       req_grant_line_zero;
		logic       operating_mode_pin;
		logic       takeover_req;
		logic       transfer_direction;
		logic       ready;
		logic [2:0] status_n;
		logic       proc_clk;
	} mbc_pins_t;

	typedef struct packed {
		logic ale;
		logic early_write_enable;
		logic write_data_enable;
		logic read_data_enable;
		logic bus_data_enable;
	} mbc_strobe_t;

	typedef struct packed {
		logic ack;
		logic ack_n;
	} mbc_ack_t;

	// second and third stage agree before a change counts
	function automatic logic [31:0] mbc_filt(input logic [31:0] s2, input logic [31:0] s3,
		input logic [31:0] f);
		return (s2 & s3) | (f & (s2 | s3));
	endfunction

endpackage

// ---- hdl/mbc_grant_seq.sv ----
// request/grant divide-by-three sequencer
module mbc_grant_seq (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              clr,
	input  wire logic              adv,
	input  wire logic              min_mode,
	output logic                   pend_q,
	output mbc_pkg::mbc_ack_t      ack_q,
	output logic                   min_ack
);

	//------------------------------------------------
	// pending / acknowledge pair
	//------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= 1'b0;
			ack_q  <= 2'b01;
		end else if (ce) begin
			if (clr) begin
				pend_q <= 1'b0; // [R24] [R11]
				ack_q  <= 2'b01;
			end else if (adv) begin
				pend_q    <= ~pend_q & ~ack_q.ack; // [R13]
				ack_q.ack <= pend_q; // [R14] [R15]
				ack_q.ack_n <= ~pend_q; // [R16]
			end
		end
	end

	assign min_ack = ack_q.ack & min_mode; // [R14]

endmodule

// ---- bench/mbc_proc_model.sv ----
// partner model: processor clock, status lines and bus grants
module mbc_proc_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       go,
	input  wire logic [2:0] code,
	input  wire logic [1:0] dut_oe,
	output logic            proc_clk,
	output logic [2:0]      status_n,
	output logic [1:0]      gnt_oe
);
	logic [3:0] phase_q;
	logic [1:0] cnt_q;
	logic       pend_q;
	logic [1:0] oe_q;
	logic [1:0] st_q [2];

	assign proc_clk = phase_q[3];

	//------------------------------
	// free running processor clock
	//------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= 4'h0;
		end else begin
			phase_q <= phase_q + 4'h1;
		end
	end

	//------------------------------
	// status leaves idle late in a high phase
	//------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_n <= 3'h7;
			cnt_q    <= 2'h0;
			pend_q   <= 1'b0;
		end else begin
			if (go) begin
				pend_q <= 1'b1;
			end
			if (phase_q == 4'hc && pend_q) begin
				status_n <= code;
				pend_q   <= 1'b0;
				cnt_q    <= 2'h2;
			end else if (phase_q == 4'hc && cnt_q != 2'h0) begin
				cnt_q <= cnt_q - 2'h1;
				if (cnt_q == 2'h1) begin
					status_n <= 3'h7;
				end
			end
		end
	end

	//------------------------------
	// grant pulse one processor clock after a request
	//------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_q   <= 2'h0;
			gnt_oe <= 2'h0;
			st_q   <= '{2'h0, 2'h0};
		end else begin
			oe_q <= dut_oe;
			for (int i = 0; i < 2; i++) begin
				if (oe_q[i] && !dut_oe[i]) begin
					st_q[i] <= (st_q[i] == 2'h0) ? 2'h1 : 2'h0;
				end else if (phase_q == 4'h0 && st_q[i] == 2'h1 && !gnt_oe[i]) begin
					gnt_oe[i] <= 1'b1;
					st_q[i]   <= 2'h2;
				end
				if (phase_q == 4'h0 && gnt_oe[i]) begin
					gnt_oe[i] <= 1'b0;
				end
			end
		end
	end
endmodule

// ---- bench/tb_max_mode_bus_control_emulation.sv ----
// self-checking bench for the bus control emulation block
module tb_max_mode_bus_control_emulation;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BDE = 0, RDE = 1, WDE = 2, EWE = 3, ALE = 4, OE0 = 5, OE1 = 6, AK0 = 7, AK1 = 8;
	logic                 pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]           paddr = 8'h00;
	logic [31:0]          pwdata = 32'h0, prdata, r, s;
	logic                 pready, pslverr, e, go = 1'b0, strap = 1'b0, sysr = 1'b0;
	logic                 mode = 1'b0, treq = 1'b0, ready = 1'b1, proc_clk, oe0, oe1, bta;
	logic [2:0]           code = 3'h7, status_n;
	logic [19:0]          addr = 20'h0, laddr;
	logic [1:0]           goe;
	mbc_pkg::mbc_pins_t   pins;
	mbc_pkg::mbc_strobe_t sb;
	mbc_pkg::mbc_ack_t    ack0, ack1;
	int                   errors = 0, samples_checked = 0, n, k;
	wire                  l0 = ~(oe0 | goe[0]);
	wire                  l1 = ~(oe1 | goe[1]);
	wire  [8:0]           watch = {ack1.ack, ack0.ack, oe1, oe0, sb};

	assign pins = {strap, sysr, l1, l0, mode, treq, code[1], ready, status_n, proc_clk};
	always #25 pclk = ~pclk;

	mbc_bus_ctl #(.AW(20)) dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .pins(pins), .addr_pins(addr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .strobes(sb), .latched_addr(laddr), .rg_zero_o(),
		.rg_zero_oe(oe0), .rg_one_o(), .rg_one_oe(oe1), .takeover_ack_zero(ack0),
		.takeover_ack_one(ack1), .bus_takeover_ack(bta));

	mbc_proc_model partner (.pclk(pclk), .presetn(presetn), .go(go), .code(code), .dut_oe({oe1, oe0}),
		.proc_clk(proc_clk), .status_n(status_n), .gnt_oe(goe));

	//------------------------------
	// shared tasks
	//------------------------------
	task automatic summarize();
		if (errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge pclk);
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int c;
		c = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			c++;
		end while (pready !== 1'b1 && c < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (c == 50) chk(0, 1, "apb hang");
	endtask

	task automatic wait_on(input int i, input logic v);
		n = 0;
		while (watch[i] !== v && n < 400) begin
			tick(1);
			n++;
		end
		if (n == 400) chk(i, 99, "wait");
	endtask

	task automatic pulse_len(input int i);
		wait_on(i, 1'b1);
		wait_on(i, 1'b0);
		chk(n, 16, "pulse length");
	endtask

	task automatic do_reset(input logic st);
		strap <= st;
		presetn <= 1'b0;
		tick(8);
		presetn <= 1'b1;
		tick(16);
	endtask

	task automatic quiet(input int i);
		k = 0;
		repeat (100) begin
			tick(1);
			k += watch[i];
		end
		chk(k, 0, "no pulse");
	endtask

	//------------------------------
	// scenarios
	//------------------------------
	task automatic t_regs();
		apb(1'b0, 8'h00, 32'h0);
		chk(r, 32'h0, "ctrl reset");
		apb(1'b0, 8'h04, 32'h0);
		chk(r, 32'h0, "status reset");
		apb(1'b1, 8'h0c, 32'h1);
		chk(e, 1'b1, "unmapped err");
		apb(1'b0, 8'h0c, 32'h0);
		chk({e, r}, {1'b1, 32'h0}, "unmapped read");
	endtask

	task automatic t_cycle(input logic [2:0] c);
		addr <= 20'ha5a50 + {17'h0, c};
		code <= c;
		go <= 1'b1;
		tick(1);
		go <= 1'b0;
		wait_on(ALE, 1'b1);
		chk(sb.early_write_enable, 1'b1, "early with strobe");
		tick(2);
		chk(sb.bus_data_enable, c[1], "data enable dir");
		wait_on(ALE, 1'b0);
		tick(2);
		chk(32'(laddr), 32'(addr), "latched address");
		apb(1'b0, 8'h08, 32'h0);
		chk(r, 32'(addr), "address register");
		wait_on(WDE, 1'b1);
		wait_on(RDE, 1'b1);
		tick(1);
		chk({sb.write_data_enable, sb.ale, sb.bus_data_enable}, 3'h5, "read enable");
		wait_on(RDE, 1'b0);
		chk(sb.early_write_enable, 1'b1, "early held");
		wait_on(EWE, 1'b0);
		chk(sb.write_data_enable, 1'b0, "write clear");
		tick(32);
	endtask

	task automatic t_halt();
		code <= 3'h3;
		go <= 1'b1;
		tick(1);
		go <= 1'b0;
		wait_on(ALE, 1'b1);
		quiet(WDE);
		apb(1'b0, 8'h04, 32'h0);
		chk(r[2:0], 3'h0, "halt no cycle");
	endtask

	task automatic t_wait();
		ready <= 1'b0;
		code <= 3'h5;
		go <= 1'b1;
		tick(1);
		go <= 1'b0;
		wait_on(RDE, 1'b1);
		tick(64);
		apb(1'b0, 8'h04, 32'h0);
		chk({sb.read_data_enable, r[2:0]}, 4'hc, "wait slot");
		ready <= 1'b1;
		wait_on(RDE, 1'b0);
		wait_on(EWE, 1'b0);
		tick(32);
	endtask

	task automatic t_grant_halt();
		apb(1'b1, 8'h00, 32'h1);
		pulse_len(OE0);
		apb(1'b0, 8'h04, 32'h0);
		chk(r[9:8], 2'h1, "pending set");
		wait_on(AK0, 1'b1);
		chk({ack0, bta}, 3'h4, "ack max mode");
		apb(1'b0, 8'h04, 32'h0);
		chk(r[9:8], 2'h2, "ack set");
		quiet(OE0);
		apb(1'b1, 8'h00, 32'h0);
		pulse_len(OE0);
		tick(4);
		chk(ack0, 2'h1, "ack released");
		apb(1'b0, 8'h04, 32'h0);
		chk(r[9:8], 2'h0, "seq idle");
	endtask

	task automatic t_grant_strap();
		do_reset(1'b1);
		treq <= 1'b1;
		quiet(OE1);
		apb(1'b0, 8'h04, 32'h0);
		chk(r[13:12], 2'h1, "strap mode");
		mode <= 1'b1;
		pulse_len(OE1);
		wait_on(AK1, 1'b1);
		chk({ack1, bta, oe0}, 4'ha, "ack min mode");
		sysr <= 1'b1;
		tick(12);
		chk(ack1, 2'h1, "sys reset clear");
		apb(1'b0, 8'h04, 32'h0);
		chk(r[11:8], 4'h0, "seq clear");
		sysr <= 1'b0;
		treq <= 1'b0;
		pulse_len(OE1);
	endtask

	initial begin
		#(40000 * 50);
		errors++;
		summarize();
	end

	initial begin
		do_reset(1'b0);
		t_regs();
		for (int i = 0; i < 7; i++) begin
			if (i != 3) t_cycle(3'(i));
		end
		t_halt();
		t_wait();
		t_grant_halt();
		t_grant_strap();
		summarize();
	end
endmodule
